// ==== osqc_cfg.svh ====
// register indices, field positions, reset values and codes of the output squelch control
`ifndef OSQC_CFG_SVH
`define OSQC_CFG_SVH

// register indices; byte address is four times the index
`define OSQC_OUT0_SUPPLY_IDX   10'h110
`define OSQC_OUT1_SUPPLY_IDX   10'h11a
`define OSQC_OUT2_SUPPLY_IDX   10'h11f
`define OSQC_OUT3_SUPPLY_IDX   10'h124
`define OSQC_OUT4_SUPPLY_IDX   10'h129
`define OSQC_OUT5_SUPPLY_IDX   10'h12e
`define OSQC_OUT6_SUPPLY_IDX   10'h133
`define OSQC_OUT0_SQUELCH_IDX  10'h111
`define OSQC_OUT1_SQUELCH_IDX  10'h116
`define OSQC_OUT2_SQUELCH_IDX  10'h11b
`define OSQC_OUT3_SQUELCH_IDX  10'h120
`define OSQC_OUT4_SQUELCH_IDX  10'h12a
`define OSQC_OUT5_SQUELCH_IDX  10'h12f
`define OSQC_OUT6_SQUELCH_IDX  10'h13f
`define OSQC_SIG_MASK_IDX      10'h141
`define OSQC_LOCK_MASK_IDX     10'h142
`define OSQC_DIS_LEVEL_IDX     10'h143
`define OSQC_STATUS_IDX        10'h144

// field positions
`define OSQC_IDX_HI            11
`define OSQC_IDX_LO            2
`define OSQC_SQ_SEL_HI         2
`define OSQC_SQ_SEL_LO         0
`define OSQC_SRC_SEL_HI        2
`define OSQC_SRC_SEL_LO        0
`define OSQC_OVR_EN_BIT        3
`define OSQC_SUPPLY_HI         5
`define OSQC_SUPPLY_LO         4
`define OSQC_REF_MASK_BIT      6
`define OSQC_DET_MASK_BIT      7
`define OSQC_LOCK_MASK_HI      3
`define OSQC_LOCK_MASK_LO      0

// reset values
`define OSQC_SUPPLY_RST        8'h08
`define OSQC_SQUELCH_RST       8'h00
`define OSQC_SIG_MASK_RST      8'h00
`define OSQC_LOCK_MASK_RST     8'h00
`define OSQC_DIS_LEVEL_RST     8'h00

// supply level applied while the override enable is clear (3.3 V)
`define OSQC_SUPPLY_DEFAULT    2'h0

// output source codes
`define OSQC_SRC_LOOP_A        3'h0
`define OSQC_SRC_LOOP_C        3'h2
`define OSQC_SRC_LOOP_D        3'h3

`endif

// ==== osqc_pkg.sv ====
// types shared by the output squelch control
package osqc_pkg;

  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    OSQC_BUS_IDLE = 2'b01,
    OSQC_BUS_ACK  = 2'b10
  } osqc_bus_e;

  // squelch source codes
  typedef enum logic [2:0] {
    OSQC_SQ_NONE   = 3'h0,
    OSQC_SQ_LOOP_A = 3'h1,
    OSQC_SQ_LOOP_B = 3'h2,
    OSQC_SQ_LOOP_C = 3'h3,
    OSQC_SQ_LOOP_D = 3'h4
  } osqc_squelch_e;

  typedef logic [7:0] osqc_byte_t;

endpackage : osqc_pkg

// ==== osqc_top.sv ====
// output squelch control: register file on avalon-mm and per-output disable gating
//
// Behaviour
// - each output holds 3-bit squelch source: 000 none, 001..100 loops A..D
// - every output selects loop A, C or D by its own field (loop B is not selectable); all outputs identical
// - supply level at bits 5:4 applies only while override enable bit 3 is 1
// - reg 0x141 bit 6 masks reference signal loss, bit 7 detector signal loss
// - 4-bit lock loss mask per loop; 0 lets lock loss disable connected outputs
// - lock mask bit 0 loop A, bit 2 loop C, bit 3 loop D
// - disabled output held at its disabled level: 0 low, 1 high
// - output source select: 0 loop A, 1 reserved, 2 loop C, 3 loop D
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "osqc_cfg.svh"

module osqc_top #(
  parameter int NUM_OUTPUTS = 7,
  parameter int NUM_LOOPS   = 4,
  parameter int ADDR_W      = 12
) (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]          address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  // loop status and clocks
  input  wire logic [NUM_LOOPS-1:0]       loop_reset,
  input  wire logic [NUM_LOOPS-1:0]       lock_loss,
  input  wire logic                       ref_signal_loss,
  input  wire logic                       detector_signal_loss,
  input  wire logic [NUM_LOOPS-1:0]       loop_clk,
  // output drivers
  output logic      [NUM_OUTPUTS-1:0]     out_clk,
  output logic      [NUM_OUTPUTS-1:0]     out_disabled,
  output logic      [2*NUM_OUTPUTS-1:0]   out_supply_level
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (NUM_OUTPUTS != 7 || NUM_LOOPS != 4 || ADDR_W < 12) begin : g_bad_cfg
    $error("osqc_top: register map serves 7 outputs, 4 loops, 12 address bits");
  end

  localparam logic [9:0] SUPPLY_IDX [7] = '{`OSQC_OUT0_SUPPLY_IDX, `OSQC_OUT1_SUPPLY_IDX,
    `OSQC_OUT2_SUPPLY_IDX, `OSQC_OUT3_SUPPLY_IDX, `OSQC_OUT4_SUPPLY_IDX,
    `OSQC_OUT5_SUPPLY_IDX, `OSQC_OUT6_SUPPLY_IDX};
  localparam logic [9:0] SQUELCH_IDX [7] = '{`OSQC_OUT0_SQUELCH_IDX, `OSQC_OUT1_SQUELCH_IDX,
    `OSQC_OUT2_SQUELCH_IDX, `OSQC_OUT3_SQUELCH_IDX, `OSQC_OUT4_SQUELCH_IDX,
    `OSQC_OUT5_SQUELCH_IDX, `OSQC_OUT6_SQUELCH_IDX};

  ////////////////////////////////////////////////////////////////////////////
  // state

  osqc_pkg::osqc_bus_e                     bus_state_reg;
  osqc_pkg::osqc_bus_e                     bus_state_next;
  logic                                    waitrequest_reg;
  logic [31:0]                             readdata_reg;
  osqc_pkg::osqc_byte_t [NUM_OUTPUTS-1:0]  supply_reg;
  osqc_pkg::osqc_byte_t [NUM_OUTPUTS-1:0]  squelch_reg;
  osqc_pkg::osqc_byte_t                    sig_mask_reg;
  osqc_pkg::osqc_byte_t                    lock_mask_reg;
  osqc_pkg::osqc_byte_t                    dis_level_reg;
  logic [NUM_OUTPUTS-1:0]                  out_clk_reg;
  logic [NUM_OUTPUTS-1:0]                  out_disabled_reg;
  logic [2*NUM_OUTPUTS-1:0]                out_supply_reg;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  logic [9:0]              reg_idx;
  logic                    aligned;
  logic                    wr_commit;
  logic                    wr_low;
  logic [NUM_OUTPUTS-1:0]  hit_supply;
  logic [NUM_OUTPUTS-1:0]  hit_squelch;
  logic                    hit_sig_mask;
  logic                    hit_lock_mask;
  logic                    hit_dis_level;
  logic                    hit_status;
  logic [7:0]              wr_byte;

  assign reg_idx       = address[`OSQC_IDX_HI:`OSQC_IDX_LO];
  // a shift instead of a part-select keeps the upper-bit test legal when ADDR_W is 12
  assign aligned       = (address[`OSQC_IDX_LO-1:0] == '0) &&
                         ((address >> (`OSQC_IDX_HI + 1)) == '0);
  assign wr_commit     = (bus_state_reg == osqc_pkg::OSQC_BUS_ACK) && write;
  assign wr_low        = wr_commit && aligned && byteenable[0];
  assign wr_byte       = writedata[7:0];
  assign hit_sig_mask  = aligned && (reg_idx == `OSQC_SIG_MASK_IDX);
  assign hit_lock_mask = aligned && (reg_idx == `OSQC_LOCK_MASK_IDX);
  assign hit_dis_level = aligned && (reg_idx == `OSQC_DIS_LEVEL_IDX);
  assign hit_status    = aligned && (reg_idx == `OSQC_STATUS_IDX);

  for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_hit
    assign hit_supply[i]  = aligned && (reg_idx == SUPPLY_IDX[i]);
    assign hit_squelch[i] = aligned && (reg_idx == SQUELCH_IDX[i]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux; unmapped addresses read zero

  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      if (hit_supply[i]) begin
        rd_byte = supply_reg[i];
      end
      if (hit_squelch[i]) begin
        rd_byte = squelch_reg[i];
      end
    end
    if (hit_sig_mask) begin
      rd_byte = sig_mask_reg;
    end
    if (hit_lock_mask) begin
      rd_byte = lock_mask_reg;
    end
    if (hit_dis_level) begin
      rd_byte = dis_level_reg;
    end
    if (hit_status) begin
      rd_byte = {1'b0, out_disabled_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: request taken in idle, answered one cycle later
  // the answer cycle always falls back to idle, so a held request gets one access per two cycles

  assign bus_state_next = (bus_state_reg == osqc_pkg::OSQC_BUS_IDLE && (read || write)) ?
                          osqc_pkg::OSQC_BUS_ACK : osqc_pkg::OSQC_BUS_IDLE;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state_reg   <= osqc_pkg::OSQC_BUS_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg    <= 32'h0000_0000;
    end else begin
      bus_state_reg   <= bus_state_next;
      waitrequest_reg <= (bus_state_next != osqc_pkg::OSQC_BUS_ACK);
      if (bus_state_next == osqc_pkg::OSQC_BUS_ACK && read) begin
        readdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers, written at the acknowledging edge

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        supply_reg[i]  <= `OSQC_SUPPLY_RST;
        squelch_reg[i] <= `OSQC_SQUELCH_RST;
      end
      sig_mask_reg  <= `OSQC_SIG_MASK_RST;
      lock_mask_reg <= `OSQC_LOCK_MASK_RST;
      dis_level_reg <= `OSQC_DIS_LEVEL_RST;
    end else if (wr_low) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        if (hit_supply[i]) begin
          supply_reg[i] <= wr_byte;
        end
        if (hit_squelch[i]) begin
          squelch_reg[i] <= wr_byte;
        end
      end
      if (hit_sig_mask) begin
        sig_mask_reg <= wr_byte;
      end
      if (hit_lock_mask) begin
        lock_mask_reg <= wr_byte;
      end
      if (hit_dis_level) begin
        dis_level_reg <= wr_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // global causes

  logic                 ref_cause;
  logic                 det_cause;
  logic [NUM_LOOPS-1:0] lock_cause;

  assign ref_cause  = ref_signal_loss && !sig_mask_reg[`OSQC_REF_MASK_BIT];
  assign det_cause  = detector_signal_loss && !sig_mask_reg[`OSQC_DET_MASK_BIT];
  // bit n of the mask guards loop n: A=0, B=1, C=2, D=3
  assign lock_cause = lock_loss & ~lock_mask_reg[`OSQC_LOCK_MASK_HI:`OSQC_LOCK_MASK_LO];

  ////////////////////////////////////////////////////////////////////////////
  // per-output gating

  logic [NUM_OUTPUTS-1:0]   disabled_w;
  logic [NUM_OUTPUTS-1:0]   clk_sel_w;
  logic [NUM_OUTPUTS-1:0]   clk_next;
  logic [2*NUM_OUTPUTS-1:0] supply_next;

  for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_out
    logic [2:0] src_sel;
    logic [2:0] sq_sel;
    logic       src_valid;
    logic [1:0] src_loop;
    logic       reset_cause;

    assign src_sel   = supply_reg[i][`OSQC_SRC_SEL_HI:`OSQC_SRC_SEL_LO];
    assign sq_sel    = squelch_reg[i][`OSQC_SQ_SEL_HI:`OSQC_SQ_SEL_LO];
    // reserved source codes carry no clock and count as disabled
    assign src_valid = (src_sel == `OSQC_SRC_LOOP_A) || (src_sel == `OSQC_SRC_LOOP_C) ||
                       (src_sel == `OSQC_SRC_LOOP_D);
    assign src_loop  = src_sel[1:0];
    // squelch codes 1..4 name loops A..D; other codes name nothing
    assign reset_cause = (sq_sel != osqc_pkg::OSQC_SQ_NONE) &&
                         (sq_sel <= osqc_pkg::OSQC_SQ_LOOP_D) &&
                         loop_reset[2'(sq_sel - 3'h1)];
    assign disabled_w[i] = reset_cause || ref_cause || det_cause || !src_valid ||
                           lock_cause[src_loop];
    assign clk_sel_w[i]  = loop_clk[src_loop];
    assign clk_next[i]   = disabled_w[i] ? dis_level_reg[i] : clk_sel_w[i];
    assign supply_next[2*i+1:2*i] = supply_reg[i][`OSQC_OVR_EN_BIT] ?
                                    supply_reg[i][`OSQC_SUPPLY_HI:`OSQC_SUPPLY_LO] :
                                    `OSQC_SUPPLY_DEFAULT;
  end

  // registered driver controls
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_clk_reg      <= '0;
      out_disabled_reg <= '1;
      out_supply_reg   <= '0;
    end else begin
      out_clk_reg      <= clk_next;
      out_disabled_reg <= disabled_w;
      out_supply_reg   <= supply_next;
    end
  end

  assign readdata         = readdata_reg;
  assign waitrequest      = waitrequest_reg;
  assign out_clk          = out_clk_reg;
  assign out_disabled     = out_disabled_reg;
  assign out_supply_level = out_supply_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_loop_reset_squelch: assert property (@(posedge core_clk) disable iff (!rst_b)
    (squelch_reg[2][2:0] == 3'h2 && loop_reset[1]) |=> out_disabled_reg[2])
    else $error("loop B reset did not squelch output 2");

  a_squelch_none_free: assert property (@(posedge core_clk) disable iff (!rst_b)
    (squelch_reg[0][2:0] == 3'h0 && !ref_cause && !det_cause && lock_cause == '0 &&
     supply_reg[0][2:0] == 3'h0) |=> !out_disabled_reg[0])
    else $error("output 0 disabled with no cause");

  a_supply_apply: assert property (@(posedge core_clk) disable iff (!rst_b)
    1'b1 |=> out_supply_reg[1:0] == ($past(supply_reg[0][3]) ? $past(supply_reg[0][5:4]) : 2'h0))
    else $error("supply level of output 0 not applied as configured");

  a_ref_loss_all: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ref_signal_loss && !sig_mask_reg[6]) |=> (&out_disabled_reg))
    else $error("unmasked reference loss left an output enabled");

  a_det_loss_all: assert property (@(posedge core_clk) disable iff (!rst_b)
    (detector_signal_loss && !sig_mask_reg[7]) |=> (&out_disabled_reg))
    else $error("unmasked detector loss left an output enabled");

  a_lock_loss_conn: assert property (@(posedge core_clk) disable iff (!rst_b)
    (supply_reg[2][2:0] == 3'h3 && lock_loss[3] && !lock_mask_reg[3]) |=> out_disabled_reg[2])
    else $error("loop D lock loss did not disable output 2");

  a_lock_mask_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    (supply_reg[1][2:0] == 3'h2 && lock_mask_reg[2] && squelch_reg[1][2:0] == 3'h0 &&
     !ref_cause && !det_cause) |=> !out_disabled_reg[1])
    else $error("masked lock loss disabled output 1");

  a_reserved_src: assert property (@(posedge core_clk) disable iff (!rst_b)
    (supply_reg[6][2:0] == 3'h1) |=> out_disabled_reg[6])
    else $error("reserved source left output 6 enabled");

  a_disabled_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    out_disabled_reg[0] |-> out_clk_reg[0] == $past(dis_level_reg[0]))
    else $error("disabled output 0 not at its disabled level");

  a_source_mux: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!disabled_w[4] && supply_reg[4][2:0] == 3'h2) |=> out_clk_reg[4] == $past(loop_clk[2]))
    else $error("output 4 not following loop C");

  a_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((read || write) && bus_state_reg == osqc_pkg::OSQC_BUS_IDLE) |=> !waitrequest_reg ##1
    waitrequest_reg)
    else $error("bus request not answered in one cycle");

endmodule : osqc_top

// ==== tb_osqc_top.sv ====
// self-checking testbench of the output squelch control
`timescale 1ns/1ps
`include "osqc_cfg.svh"

module tb_osqc_top;
  logic        core_clk;
  logic        rst_b;
  logic [11:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  loop_reset;
  logic [3:0]  lock_loss;
  logic        ref_signal_loss;
  logic        detector_signal_loss;
  logic [3:0]  loop_clk;
  logic [6:0]  out_clk;
  logic [6:0]  out_disabled;
  logic [13:0] out_supply_level;
  int          miscompares;
  int          samples_checked;
  logic [31:0] rd_data;
  // supply/source and squelch register indices per output
  localparam logic [9:0] SUP [7] = '{`OSQC_OUT0_SUPPLY_IDX, `OSQC_OUT1_SUPPLY_IDX,
    `OSQC_OUT2_SUPPLY_IDX, `OSQC_OUT3_SUPPLY_IDX, `OSQC_OUT4_SUPPLY_IDX,
    `OSQC_OUT5_SUPPLY_IDX, `OSQC_OUT6_SUPPLY_IDX};
  localparam logic [9:0] SQ [7] = '{`OSQC_OUT0_SQUELCH_IDX, `OSQC_OUT1_SQUELCH_IDX,
    `OSQC_OUT2_SQUELCH_IDX, `OSQC_OUT3_SQUELCH_IDX, `OSQC_OUT4_SQUELCH_IDX,
    `OSQC_OUT5_SQUELCH_IDX, `OSQC_OUT6_SQUELCH_IDX};
  // source code per output: 0 loop A, 2 loop C, 3 loop D
  localparam logic [2:0] SRC [7] = '{3'h0, 3'h2, 3'h3, 3'h0, 3'h2, 3'h3, 3'h0};

  osqc_top dut (
    .core_clk(core_clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
    .waitrequest(waitrequest), .loop_reset(loop_reset), .lock_loss(lock_loss),
    .ref_signal_loss(ref_signal_loss), .detector_signal_loss(detector_signal_loss),
    .loop_clk(loop_clk), .out_clk(out_clk), .out_disabled(out_disabled),
    .out_supply_level(out_supply_level));

  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // loop clocks as counter bits, so each loop toggles at its own rate
  always @(posedge core_clk) begin
    loop_clk <= loop_clk + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // comparison, verdict and bus cycles
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    address   <= {idx, 2'b00};
    read      <= ~wr;
    write     <= wr;
    writedata <= {24'h0, wd};
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    rd_data = readdata;
    read    <= 1'b0;
    write   <= 1'b0;
    if (n >= 40) begin
      miscompares++;
      summarize();
    end
  endtask : bus

  task automatic rdchk(input string what, input logic [9:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(what, {24'h0, exp}, rd_data);
  endtask : rdchk

  // let register writes and input changes reach the outputs
  task automatic settle();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  task automatic drive(input logic [3:0] rs, input logic [3:0] ll, input logic r, input logic d);
    @(posedge core_clk);
    loop_reset           <= rs;
    lock_loss            <= ll;
    ref_signal_loss      <= r;
    detector_signal_loss <= d;
    settle();
  endtask : drive

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      rdchk("supply reg", SUP[i], `OSQC_SUPPLY_RST);
      rdchk("squelch reg", SQ[i], `OSQC_SQUELCH_RST);
    end
    rdchk("signal mask", `OSQC_SIG_MASK_IDX, `OSQC_SIG_MASK_RST);
    rdchk("lock mask", `OSQC_LOCK_MASK_IDX, `OSQC_LOCK_MASK_RST);
    rdchk("unmapped", 10'h100, 8'h00);
    chk("disabled", 32'h0, 32'(out_disabled));
  endtask : t_reset

  task automatic t_source();
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, SUP[i], {5'h01, SRC[i]});
    end
    settle();
    repeat (4) begin
      @(negedge core_clk);
      for (int i = 0; i < 7; i++) begin
        chk("out clk", 32'((loop_clk - 4'h1) >> SRC[i]) & 32'h1, 32'(out_clk[i]));
      end
    end
    bus(1'b1, SUP[6], 8'h09);
    settle();
    chk("reserved src", 32'h40, 32'(out_disabled));
    bus(1'b1, SUP[6], 8'h08);
  endtask : t_source

  task automatic t_squelch();
    bus(1'b1, `OSQC_DIS_LEVEL_IDX, 8'h04);
    rdchk("dis level", `OSQC_DIS_LEVEL_IDX, 8'h04);
    for (int c = 0; c < 5; c++) begin
      bus(1'b1, SQ[2], 8'(c));
      rdchk("squelch reg", SQ[2], 8'(c));
      drive((c == 0) ? 4'hf : 4'(1 << (c - 1)), 4'h0, 1'b0, 1'b0);
      chk("squelch", (c == 0) ? 32'h0 : 32'h4, 32'(out_disabled));
      if (c > 0) begin
        chk("level", 32'h1, 32'(out_clk[2]));
        drive(~4'(1 << (c - 1)), 4'h0, 1'b0, 1'b0);
        chk("other reset", 32'h0, 32'(out_disabled));
      end
    end
    drive(4'h0, 4'h0, 1'b0, 1'b0);
  endtask : t_squelch

  task automatic t_sigloss();
    logic [7:0] mk [4] = '{8'h00, 8'h40, 8'h40, 8'hc0};
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `OSQC_SIG_MASK_IDX, mk[k]);
      drive(4'h0, 4'h0, k < 2, k >= 2);
      chk("signal loss", (k % 2 == 0) ? 32'h7f : 32'h0, 32'(out_disabled));
      rdchk("status", `OSQC_STATUS_IDX, (k % 2 == 0) ? 8'h7f : 8'h00);
    end
    drive(4'h0, 4'h0, 1'b0, 1'b0);
  endtask : t_sigloss

  task automatic t_lock();
    logic [6:0] exp;
    for (int l = 0; l < 4; l++) begin
      exp = 7'h0;
      for (int i = 0; i < 7; i++) begin
        exp[i] = (SRC[i] == 3'(l));
      end
      bus(1'b1, `OSQC_LOCK_MASK_IDX, 8'h00);
      drive(4'h0, 4'(1 << l), 1'b0, 1'b0);
      chk("lock loss", 32'(exp), 32'(out_disabled));
      bus(1'b1, `OSQC_LOCK_MASK_IDX, 8'(1 << l));
      settle();
      chk("lock masked", 32'h0, 32'(out_disabled));
    end
    drive(4'h0, 4'h0, 1'b0, 1'b0);
  endtask : t_lock

  task automatic t_supply();
    for (int v = 0; v < 5; v++) begin
      bus(1'b1, SUP[4], (v < 4) ? {2'h0, 2'(v), 4'ha} : 8'hca);
      settle();
      chk("supply", (v < 4) ? 32'(v) : 32'h0, 32'(out_supply_level[9:8]));
    end
    rdchk("supply reg", SUP[4], 8'hca);
  endtask : t_supply

  ////////////////////////////////////////////////////////////////////////////////
  // reset for three cycles, then the scenarios
  initial begin
    miscompares = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    address = 12'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    loop_reset = 4'h0;
    lock_loss = 4'h0;
    ref_signal_loss = 1'b0;
    detector_signal_loss = 1'b0;
    loop_clk = 4'h0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    settle();
    t_reset();
    t_source();
    t_squelch();
    t_sigloss();
    t_lock();
    t_supply();
    summarize();
  end
endmodule : tb_osqc_top
